// >>> verilog/uahc_consts.svh
// Purpose: Offsets, field positions and reset values of the front-end control bank
// Assumes: 32-bit classic Wishbone, byte addresses, word aligned
// Notes:   Definitions only
`ifndef UAHC_CONSTS_SVH
`define UAHC_CONSTS_SVH

// ============================================================
// Register offsets
`define UAHC_OFS_AFE_CTRL   12'h0c8
`define UAHC_OFS_PORT_EN    12'h140
`define UAHC_OFS_EVT_STAT   12'h200
`define UAHC_OFS_EVT_EN     12'h204
`define UAHC_OFS_EVT_CLR    12'h208

// ============================================================
// Field positions
`define UAHC_BIT_TERM       29
`define UAHC_BIT_SQUELCH    28
`define UAHC_BIT_DISC       27
`define UAHC_SQT_HI         26
`define UAHC_SQT_LO         24
`define UAHC_BIT_MODE       24
`define UAHC_BIT_IMP        18
`define UAHC_BIT_SLEW       17
`define UAHC_BIT_SWAP       16
`define UAHC_EVT_DISC       0
`define UAHC_EVT_SQUELCH    1

// ============================================================
// Reset values and masks
`define UAHC_RST_SQT        3'h0
`define UAHC_RST_BIT        1'h0
`define UAHC_RST_EVT        2'h0
`define UAHC_MASK_CTRL      32'h3f00_0000
`define UAHC_MASK_PORT      32'h0107_0000
`define UAHC_MASK_EVT       32'h0000_0003
`define UAHC_RD_ZERO        32'h0000_0000

`endif

// >>> verilog/uahc_pkg.sv
// Purpose: Types shared by the front-end control bank
// Assumes: Constants come from uahc_consts.svh
// Notes:   Packed structs carry grouped signals
package uahc_pkg;

	// ============================================================
	// Configuration image presented by the loader
	typedef struct packed {
		logic [2:0] squelch_threshold;
		logic       pad_impedance;
		logic       slew_adjust;
		logic       swap;
	} uahc_image_t;

	// ============================================================
	// Settings driven to the analog front end and pads
	typedef struct packed {
		logic       hs_termination_on;
		logic [2:0] squelch_threshold_tune;
		logic       interchip_mode_select;
		logic       pad_impedance_select;
		logic       pad_slew_adjust;
		logic       data_strobe_swap;
	} uahc_afe_cfg_t;

	// ============================================================
	// Whole state of the bank
	typedef struct packed {
		logic          ack;
		logic [31:0]   rdata;
		uahc_afe_cfg_t cfg;
		uahc_image_t   img;
		logic          sq_s1;
		logic          sq_s2;
		logic          dc_s1;
		logic          dc_s2;
		logic          disc_flag;
		logic          sq_prev;
		logic          strap_pend;
		logic [1:0]    evt_stat;
		logic [1:0]    evt_en;
	} uahc_state_t;

endpackage : uahc_pkg

// >>> verilog/uahc_regs.sv
// Purpose: Front-end and inter-chip port control registers on classic Wishbone
// Assumes: Loader resolves EEPROM, OTP or zero into image inputs
// Notes:   Single clock, synchronous reset, clock enable freezes all state
//
// Behaviour
// - Bit 29 drives HS termination enable
// - Bit 28 shows active-low squelch status
// - Bit 27 shows HS disconnect status
// - Disconnect captured only at EOP bit 32
// - Bits 26:24 pass squelch tune code
// - Reset protection shields squelch tune field
// - Squelch tune loads image value, else zero
// - USB or lite reset restores squelch image
// - Port bit 24 selects USB or inter-chip
// - Mode resets to strap pin level
// - Bit 18 selects 40 or 50 ohm
// - Bit 17 enables 30 percent slew adjust
// - Bit 16 swaps data and strobe pins
// - Pad bits load and restore image values
`timescale 1ns/10ps
`include "uahc_consts.svh"

module uahc_regs
	import uahc_pkg::*;
#(
	parameter int ADDR_W = 12
)(
	input  wire logic              clk,
	input  wire logic              sys_rst,
	input  wire logic              ce,
	input  wire logic [ADDR_W-1:0] wb_adr_i,
	input  wire logic [31:0]       wb_dat_i,
	input  wire logic [3:0]        wb_sel_i,
	input  wire logic              wb_we_i,
	input  wire logic              wb_cyc_i,
	input  wire logic              wb_stb_i,
	output logic [31:0]            wb_dat_o,
	output logic                   wb_ack_o,
	input  wire logic              afe_squelch_n,
	input  wire logic              afe_disconnect,
	input  wire logic              hs_eop_bit32,
	input  wire logic              interchip_strap_pin,
	input  wire logic              image_load,
	input  wire uahc_image_t       image_in,
	input  wire logic              usb_reset,
	input  wire logic              lite_reset,
	input  wire logic              reset_protect,
	output uahc_afe_cfg_t          afe_cfg,
	output logic                   irq
);

	// ============================================================
	// Address decode
	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [11:0] ofs);
		hit = (a[ADDR_W-1:2] == ofs[ADDR_W-1:2]);
	endfunction : hit

	uahc_state_t q_reg;
	uahc_state_t q_next;
	logic        req;
	logic        wr_ctrl;
	logic        wr_port;
	logic        rst_evt;
	logic        sq_wr;
	logic        pad_wr;
	logic        rd_ctrl;
	logic        clr_wr;

	assign req     = wb_cyc_i && wb_stb_i && !q_reg.ack;
	assign wr_ctrl = req && wb_we_i && hit(wb_adr_i, `UAHC_OFS_AFE_CTRL);
	assign wr_port = req && wb_we_i && hit(wb_adr_i, `UAHC_OFS_PORT_EN);
	assign rst_evt = usb_reset || lite_reset;
	assign sq_wr   = wr_ctrl && wb_sel_i[3];
	assign pad_wr  = wr_port && wb_sel_i[2];
	assign rd_ctrl = req && !wb_we_i && hit(wb_adr_i, `UAHC_OFS_AFE_CTRL);
	assign clr_wr  = req && wb_we_i && hit(wb_adr_i, `UAHC_OFS_EVT_CLR) && wb_sel_i[0];

	// ============================================================
	// Next state
	always_comb
	begin
		q_next     = q_reg;
		q_next.ack = req;
		// Two-flop synchronisers, second stage is the only reader
		q_next.sq_s1 = afe_squelch_n;
		q_next.sq_s2 = q_reg.sq_s1;
		q_next.dc_s1 = afe_disconnect;
		q_next.dc_s2 = q_reg.dc_s1;
		q_next.sq_prev = q_reg.sq_s2;
		// Disconnect is only meaningful at the 32nd bit of an HS EOP
		if (hs_eop_bit32)
		begin
			q_next.disc_flag = q_reg.dc_s2;
		end

		// Bus writes, reserved bits dropped by field picking
		if (wr_ctrl && wb_sel_i[3])
		begin
			q_next.cfg.hs_termination_on = wb_dat_i[`UAHC_BIT_TERM];
			q_next.cfg.squelch_threshold_tune =
				wb_dat_i[`UAHC_SQT_HI:`UAHC_SQT_LO];
		end
		if (wr_port && wb_sel_i[3])
		begin
			q_next.cfg.interchip_mode_select = wb_dat_i[`UAHC_BIT_MODE];
		end
		if (wr_port && wb_sel_i[2])
		begin
			q_next.cfg.pad_impedance_select = wb_dat_i[`UAHC_BIT_IMP];
			q_next.cfg.pad_slew_adjust = wb_dat_i[`UAHC_BIT_SLEW];
			q_next.cfg.data_strobe_swap = wb_dat_i[`UAHC_BIT_SWAP];
		end
		if (req && wb_we_i && hit(wb_adr_i, `UAHC_OFS_EVT_EN) && wb_sel_i[0])
		begin
			q_next.evt_en = wb_dat_i[1:0];
		end
		if (req && wb_we_i && hit(wb_adr_i, `UAHC_OFS_EVT_CLR) && wb_sel_i[0])
		begin
			q_next.evt_stat = q_reg.evt_stat & ~wb_dat_i[1:0];
		end

		// USB or lite reset restores the last image; protection keeps the tune
		if (rst_evt)
		begin
			if (!reset_protect)
			begin
				q_next.cfg.squelch_threshold_tune = q_reg.img.squelch_threshold;
			end
			q_next.cfg.pad_impedance_select = q_reg.img.pad_impedance;
			q_next.cfg.pad_slew_adjust = q_reg.img.slew_adjust;
			q_next.cfg.data_strobe_swap = q_reg.img.swap;
		end
		// Image load wins over everything: it is the new default
		if (image_load)
		begin
			q_next.img = image_in;
			q_next.cfg.squelch_threshold_tune = image_in.squelch_threshold;
			q_next.cfg.pad_impedance_select = image_in.pad_impedance;
			q_next.cfg.pad_slew_adjust = image_in.slew_adjust;
			q_next.cfg.data_strobe_swap = image_in.swap;
		end
		// Strap taken one clocked cycle after reset release
		if (q_reg.strap_pend)
		begin
			q_next.strap_pend = 1'b0;
			q_next.cfg.interchip_mode_select = interchip_strap_pin;
		end

		// Event capture: set wins over a clear in the same cycle
		if (hs_eop_bit32 && q_reg.dc_s2 && !q_reg.disc_flag)
		begin
			q_next.evt_stat[`UAHC_EVT_DISC] = 1'b1;
		end
		if (q_reg.sq_s2 && !q_reg.sq_prev)
		begin
			q_next.evt_stat[`UAHC_EVT_SQUELCH] = 1'b1;
		end

		// Read data; unmapped and write-only addresses read zero
		q_next.rdata = `UAHC_RD_ZERO;
		if (req && !wb_we_i)
		begin
			if (hit(wb_adr_i, `UAHC_OFS_AFE_CTRL))
			begin
				q_next.rdata[`UAHC_BIT_TERM] = q_reg.cfg.hs_termination_on;
				q_next.rdata[`UAHC_BIT_SQUELCH] = q_reg.sq_s2;
				q_next.rdata[`UAHC_BIT_DISC] = q_reg.disc_flag;
				q_next.rdata[`UAHC_SQT_HI:`UAHC_SQT_LO] =
					q_reg.cfg.squelch_threshold_tune;
			end
			else if (hit(wb_adr_i, `UAHC_OFS_PORT_EN))
			begin
				q_next.rdata[`UAHC_BIT_MODE] = q_reg.cfg.interchip_mode_select;
				q_next.rdata[`UAHC_BIT_IMP] = q_reg.cfg.pad_impedance_select;
				q_next.rdata[`UAHC_BIT_SLEW] = q_reg.cfg.pad_slew_adjust;
				q_next.rdata[`UAHC_BIT_SWAP] = q_reg.cfg.data_strobe_swap;
			end
			else if (hit(wb_adr_i, `UAHC_OFS_EVT_STAT))
			begin
				q_next.rdata[1:0] = q_reg.evt_stat;
			end
			else if (hit(wb_adr_i, `UAHC_OFS_EVT_EN))
			begin
				q_next.rdata[1:0] = q_reg.evt_en;
			end
		end
	end

	// ============================================================
	// State register
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			q_reg                 <= '0;
			q_reg.cfg.squelch_threshold_tune <= `UAHC_RST_SQT;
			q_reg.img.squelch_threshold      <= `UAHC_RST_SQT;
			q_reg.evt_stat        <= `UAHC_RST_EVT;
			q_reg.evt_en          <= `UAHC_RST_EVT;
			q_reg.strap_pend      <= 1'b1;
		end
		else if (ce)
		begin
			q_reg <= q_next;
		end
	end

	// ============================================================
	// Outputs
	assign wb_ack_o = q_reg.ack;
	assign wb_dat_o = q_reg.rdata;
	assign afe_cfg  = q_reg.cfg;
	assign irq      = |(q_reg.evt_stat & q_reg.evt_en);

	// ============================================================
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	property p_ack_single;
		(ce && wb_ack_o) |=> !wb_ack_o;
	endproperty
	a_ack_single: assert property (p_ack_single) else $error("ack held over two cycles");

	property p_ack_answer;
		(ce && wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o;
	endproperty
	a_ack_answer: assert property (p_ack_answer) else $error("request not acknowledged");

	property p_term_write;
		(ce && wr_ctrl && wb_sel_i[3])
			|=> afe_cfg.hs_termination_on == $past(wb_dat_i[29]);
	endproperty
	a_term_write: assert property (p_term_write) else $error("termination not written");

	sequence s_two_ce;
		ce ##1 ce;
	endsequence
	property p_squelch_sync;
		s_two_ce |=> q_reg.sq_s2 == $past(afe_squelch_n, 2);
	endproperty
	a_squelch_sync: assert property (p_squelch_sync) else $error("squelch sync lag wrong");

	property p_disc_hold;
		!(ce && hs_eop_bit32) |=> $stable(q_reg.disc_flag);
	endproperty
	a_disc_hold: assert property (p_disc_hold) else $error("disconnect moved off strobe");

	property p_disc_capture;
		(ce && hs_eop_bit32) |=> q_reg.disc_flag == $past(q_reg.dc_s2);
	endproperty
	a_disc_capture: assert property (p_disc_capture) else $error("disconnect not captured");

	property p_restore;
		(ce && rst_evt && !image_load && !reset_protect && !q_reg.strap_pend)
			|=> afe_cfg.squelch_threshold_tune == $past(q_reg.img.squelch_threshold)
			&& afe_cfg.data_strobe_swap == $past(q_reg.img.swap);
	endproperty
	a_restore: assert property (p_restore) else $error("reset restore failed");

	property p_protect;
		(ce && rst_evt && reset_protect && !image_load && !sq_wr)
			|=> $stable(afe_cfg.squelch_threshold_tune);
	endproperty
	a_protect: assert property (p_protect) else $error("protected field overwritten");

	property p_image;
		(ce && image_load)
			|=> afe_cfg.squelch_threshold_tune == $past(image_in.squelch_threshold)
			&& afe_cfg.pad_impedance_select == $past(image_in.pad_impedance);
	endproperty
	a_image: assert property (p_image) else $error("image not loaded");

	property p_strap;
		(ce && q_reg.strap_pend)
			|=> afe_cfg.interchip_mode_select == $past(interchip_strap_pin);
	endproperty
	a_strap: assert property (p_strap) else $error("strap not taken");

	property p_reserved;
		wb_ack_o |-> (wb_dat_o & ~(`UAHC_MASK_CTRL | `UAHC_MASK_PORT | `UAHC_MASK_EVT)) == 0;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved bits read nonzero");

	// ============================================================
	// Field checks: each antecedent leaves out the higher-priority sources
	property p_tune_write;
		(ce && sq_wr && !rst_evt && !image_load)
			|=> afe_cfg.squelch_threshold_tune == $past(wb_dat_i[26:24]);
	endproperty
	a_tune_write: assert property (p_tune_write) else $error("tune not written");

	property p_mode_write;
		(ce && wr_port && wb_sel_i[3] && !q_reg.strap_pend)
			|=> afe_cfg.interchip_mode_select == $past(wb_dat_i[24]);
	endproperty
	a_mode_write: assert property (p_mode_write) else $error("mode not written");

	property p_mode_kept;
		(ce && !(wr_port && wb_sel_i[3]) && !q_reg.strap_pend)
			|=> $stable(afe_cfg.interchip_mode_select);
	endproperty
	a_mode_kept: assert property (p_mode_kept) else $error("mode moved unasked");

	sequence s_pad_write;
		ce && pad_wr && !rst_evt && !image_load;
	endsequence
	property p_imp_write;
		s_pad_write |=> afe_cfg.pad_impedance_select == $past(wb_dat_i[18]);
	endproperty
	a_imp_write: assert property (p_imp_write) else $error("impedance not written");

	property p_slew_write;
		s_pad_write |=> afe_cfg.pad_slew_adjust == $past(wb_dat_i[17]);
	endproperty
	a_slew_write: assert property (p_slew_write) else $error("slew not written");

	property p_swap_write;
		s_pad_write |=> afe_cfg.data_strobe_swap == $past(wb_dat_i[16]);
	endproperty
	a_swap_write: assert property (p_swap_write) else $error("swap not written");

	property p_term_hold;
		!(ce && sq_wr) |=> $stable(afe_cfg.hs_termination_on);
	endproperty
	a_term_hold: assert property (p_term_hold) else $error("termination moved");

	property p_pad_restore;
		(ce && rst_evt && !image_load)
			|=> afe_cfg.pad_impedance_select == $past(q_reg.img.pad_impedance)
			&& afe_cfg.pad_slew_adjust == $past(q_reg.img.slew_adjust);
	endproperty
	a_pad_restore: assert property (p_pad_restore) else $error("pads not restored");

	property p_image_pads;
		(ce && image_load)
			|=> afe_cfg.pad_slew_adjust == $past(image_in.slew_adjust)
			&& afe_cfg.data_strobe_swap == $past(image_in.swap);
	endproperty
	a_image_pads: assert property (p_image_pads) else $error("pad image not loaded");

	// ============================================================
	// Read path and events
	property p_squelch_read;
		(ce && rd_ctrl) |=> wb_dat_o[28] == $past(q_reg.sq_s2);
	endproperty
	a_squelch_read: assert property (p_squelch_read) else $error("squelch misread");

	property p_disc_read;
		(ce && rd_ctrl) |=> wb_dat_o[27] == $past(q_reg.disc_flag);
	endproperty
	a_disc_read: assert property (p_disc_read) else $error("disconnect misread");

	property p_tune_read;
		(ce && rd_ctrl) |=> wb_dat_o[26:24] == $past(afe_cfg.squelch_threshold_tune);
	endproperty
	a_tune_read: assert property (p_tune_read) else $error("tune misread");

	property p_idle_data;
		!wb_ack_o |-> wb_dat_o == `UAHC_RD_ZERO;
	endproperty
	a_idle_data: assert property (p_idle_data) else $error("data outside ack");

	property p_disc_event;
		(ce && hs_eop_bit32 && q_reg.dc_s2 && !q_reg.disc_flag)
			|=> q_reg.evt_stat[`UAHC_EVT_DISC];
	endproperty
	a_disc_event: assert property (p_disc_event) else $error("disconnect event lost");

	property p_evt_clear;
		(ce && clr_wr && !hs_eop_bit32 && !(q_reg.sq_s2 && !q_reg.sq_prev))
			|=> q_reg.evt_stat == ($past(q_reg.evt_stat) & ~$past(wb_dat_i[1:0]));
	endproperty
	a_evt_clear: assert property (p_evt_clear) else $error("event clear wrong");

	// Frozen clock enable must leave every flop, ack included, untouched
	property p_freeze;
		!ce |=> $stable(q_reg);
	endproperty
	a_freeze: assert property (p_freeze) else $error("state moved with ce low");

endmodule : uahc_regs

// >>> test/uahc_afe_model.sv
// Purpose: Front-end stand-in for squelch, disconnect and EOP strobe
// Assumes: Bench sets request levels after clock edges
// Notes:   Strobe is held back until disconnect is steady two cycles
`timescale 1ns/10ps

module uahc_afe_model (
	input  wire logic clk,
	input  wire logic sq_req,
	input  wire logic dc_req,
	input  wire logic eop_req,
	output logic      afe_squelch_n,
	output logic      afe_disconnect,
	output logic      hs_eop_bit32
);
	// ============================================================
	// Line state
	logic [1:0] steady_reg;

	initial
	begin
		afe_squelch_n = 1'b0;
		afe_disconnect = 1'b0;
		hs_eop_bit32 = 1'b0;
		steady_reg = 2'h0;
	end

	always @(posedge clk)
	begin
		afe_squelch_n <= sq_req;
		afe_disconnect <= dc_req;
		if (dc_req != afe_disconnect)
			steady_reg <= 2'h0;
		else if (steady_reg != 2'h3)
			steady_reg <= steady_reg + 2'h1;
		// A strobe on a moving line would be dropped, as the real front end does
		hs_eop_bit32 <= eop_req && (steady_reg >= 2'h2);
	end
endmodule : uahc_afe_model

// >>> test/usb_afe_hsic_control_regs_bench.sv
// Purpose: Self-checking bench for the front-end control bank
// Assumes: Classic Wishbone, strap and ce driven by the bench
// Notes:   Expected values come from integer model below
`timescale 1ns/10ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin failures++; \
	$display("FAIL t=%0t got=%h exp=%h", $time, g, e); end end

module usb_afe_hsic_control_regs_bench
	import uahc_pkg::*;
;
	// ============================================================
	// Signals
	logic clk, sys_rst, we, cyc, stb, ack, irq, ce, strap;
	logic [11:0] adr;
	logic [31:0] dw, dr, q, d;
	logic [3:0] sel;
	logic sq_req, dc_req, eop_req, sq_n, dc, eop, ld, usb_rst, lite_rst, prot;
	uahc_image_t img;
	uahc_afe_cfg_t cfg;
	int failures, check_count, cycles, seed, i;
	logic [31:0] e_ctrl, e_port, e_stat, e_sq, e_dc;

	uahc_afe_model u_afe (.clk(clk), .sq_req(sq_req), .dc_req(dc_req), .eop_req(eop_req),
		.afe_squelch_n(sq_n), .afe_disconnect(dc), .hs_eop_bit32(eop));

	uahc_regs u_dut (.clk(clk), .sys_rst(sys_rst), .ce(ce), .wb_adr_i(adr),
		.wb_dat_i(dw), .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_dat_o(dr), .wb_ack_o(ack), .afe_squelch_n(sq_n), .afe_disconnect(dc),
		.hs_eop_bit32(eop), .interchip_strap_pin(strap), .image_load(ld), .image_in(img),
		.usb_reset(usb_rst), .lite_reset(lite_rst), .reset_protect(prot),
		.afe_cfg(cfg), .irq(irq));

	always #2.5 clk = ~clk;

	// ============================================================
	// Tasks
	task automatic test_done();
		$display("checks %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : test_done

	task automatic wb(input logic [11:0] a, input logic w, input logic [31:0] v);
		@(posedge clk);
		adr <= a;
		we <= w;
		dw <= v;
		sel <= 4'hf;
		cyc <= 1'b1;
		stb <= 1'b1;
		do
		begin
			@(posedge clk);
		end
		while (ack !== 1'b1);
		q = dr;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask : wb

	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		wb(a, 1'b0, 32'h0);
		`CHK(q, e)
	endtask : rd

	function automatic logic [31:0] ctrl_e();
		return e_ctrl | (e_sq << 28) | (e_dc << 27);
	endfunction : ctrl_e

	function automatic logic [8:0] cfg_e();
		return {e_ctrl[29], e_ctrl[26:24], e_port[24], e_port[18:16]};
	endfunction : cfg_e

	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			failures++;
			test_done();
		end
	end

	// ============================================================
	// Sequence
	initial
	begin
		{clk, we, cyc, stb, sq_req, dc_req, eop_req, ld, usb_rst, lite_rst, prot} = 0;
		{adr, dw, sel, img, failures, check_count, cycles, e_ctrl, e_stat, e_sq, e_dc} = 0;
		seed = 33;
		ce = 1'b1;
		strap = 1'b1;
		sys_rst = 1'b1;
		repeat (8) @(posedge clk);
		sys_rst <= 1'b0;
		e_port = 32'h0100_0000;
		rd(12'h0c8, 32'h0);
		rd(12'h140, e_port);
		`CHK(cfg, cfg_e())
		for (i = 0; i < 4; i++)
		begin
			d = $random(seed);
			wb(12'h0c8, 1'b1, d);
			e_ctrl = d & 32'h2700_0000;
			rd(12'h0c8, ctrl_e());
			`CHK(cfg, cfg_e())
			d = $random(seed);
			wb(12'h140, 1'b1, d);
			e_port = d & 32'h0107_0000;
			rd(12'h140, e_port);
			`CHK(cfg, cfg_e())
		end
		wb(12'h204, 1'b1, 32'h1);
		sq_req <= 1'b1;
		e_sq = 1;
		e_stat = 2;
		repeat (6) @(posedge clk);
		rd(12'h0c8, ctrl_e());
		rd(12'h200, e_stat);
		`CHK(irq, 1'b0)
		dc_req <= 1'b1;
		repeat (4) @(posedge clk);
		eop_req <= 1'b1;
		@(posedge clk);
		eop_req <= 1'b0;
		repeat (6) @(posedge clk);
		e_dc = 1;
		e_stat = 3;
		rd(12'h0c8, ctrl_e());
		`CHK(irq, 1'b1)
		dc_req <= 1'b0;
		repeat (6) @(posedge clk);
		rd(12'h0c8, ctrl_e());
		eop_req <= 1'b1;
		@(posedge clk);
		eop_req <= 1'b0;
		repeat (6) @(posedge clk);
		e_dc = 0;
		rd(12'h0c8, ctrl_e());
		wb(12'h208, 1'b1, 32'h3);
		rd(12'h200, 32'h0);
		`CHK(irq, 1'b0)
		wb(12'h300, 1'b1, 32'hffff_ffff);
		rd(12'h300, 32'h0);
		rd(12'h208, 32'h0);
		for (i = 0; i < 2; i++)
		begin
			d = $random(seed);
			img <= d[5:0];
			ld <= 1'b1;
			@(posedge clk);
			ld <= 1'b0;
			@(posedge clk);
			e_ctrl = (e_ctrl & 32'h2000_0000) | ({29'h0, d[5:3]} << 24);
			e_port = (e_port & 32'h0100_0000) | ({29'h0, d[2:0]} << 16);
			`CHK(cfg, cfg_e())
			wb(12'h0c8, 1'b1, ~e_ctrl);
			wb(12'h140, 1'b1, ~e_port);
			e_ctrl = ~e_ctrl & 32'h2700_0000;
			e_port = ~e_port & 32'h0107_0000;
			prot <= i[0];
			usb_rst <= ~i[0];
			lite_rst <= i[0];
			@(posedge clk);
			{usb_rst, lite_rst, prot} <= 3'h0;
			@(posedge clk);
			if (i == 0)
				e_ctrl = (e_ctrl & 32'h2000_0000) | ({29'h0, d[5:3]} << 24);
			e_port = (e_port & 32'h0100_0000) | ({29'h0, d[2:0]} << 16);
			`CHK(cfg, cfg_e())
		end
		// Second reset with the strap low: the port must come up in USB mode
		strap <= 1'b0;
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		e_ctrl = 32'h0;
		e_port = 32'h0;
		rd(12'h140, e_port);
		`CHK(cfg, cfg_e())
		// Clock enable low: image load and restore are both ignored
		ce <= 1'b0;
		img <= 6'h3f;
		ld <= 1'b1;
		usb_rst <= 1'b1;
		repeat (3) @(posedge clk);
		`CHK(cfg, cfg_e())
		ld <= 1'b0;
		usb_rst <= 1'b0;
		ce <= 1'b1;
		@(posedge clk);
		`CHK(cfg, cfg_e())
		test_done();
	end
endmodule : usb_afe_hsic_control_regs_bench
